// ==== power_mode_defines.svh ====
// timing counts, opcodes and reset values of the power and page-size control
`ifndef POWER_MODE_DEFINES_SVH
`define POWER_MODE_DEFINES_SVH
// core clock rate in MHz
`define CLK_MHZ              50
// single-byte opcodes
`define OP_RESUME_DEEP       8'hab
`define OP_ENTER_DEEP        8'hb9
`define OP_ENTER_ULTRA       8'h79
// four-byte page-size sequence
`define CFG_BYTE0            8'h3d
`define CFG_BYTE1            8'h2a
`define CFG_BYTE2            8'h80
`define CFG_BYTE3_256        8'ha6
`define CFG_BYTE3_264        8'ha7
`define CFG_LAST_INDEX       3'd3
// page and buffer sizes in bytes
`define PAGE_BYTES_256       9'h100
`define PAGE_BYTES_264       9'h108
`define PAGE_264_RESET       1'b1
// times in their own units, counts derived from the clock rate
`define RESUME_DELAY_US      35
`define RESUME_DELAY_CYC     (`RESUME_DELAY_US * `CLK_MHZ)
`define ULTRA_ENTRY_DELAY_US 3
`define ULTRA_ENTRY_CYC      (`ULTRA_ENTRY_DELAY_US * `CLK_MHZ)
`define EXIT_PULSE_MIN_LOW_NS 20
`define EXIT_PULSE_MIN_CYC   ((`EXIT_PULSE_MIN_LOW_NS * `CLK_MHZ + 999) / 1000)
`define ULTRA_EXIT_DELAY_US  100
`define ULTRA_EXIT_CYC       (`ULTRA_EXIT_DELAY_US * `CLK_MHZ)
`define CONFIG_PROGRAM_TIME_US 50000
`define CONFIG_PROGRAM_CYC   (`CONFIG_PROGRAM_TIME_US * `CLK_MHZ)
`endif

// ==== power_mode_pkg.sv ====
// types shared by the power and page-size control
package power_mode_pkg;
  // ****************************************
  // power state, gray coded except standby to deep, deep resume to standby and the long-low ultra exit
  // ****************************************
  typedef enum logic [2:0] {
    ST_STANDBY     = 3'h0,  // awake, commands accepted
    ST_ULTRA_ENTRY = 3'h1,  // entering ultra-deep power-down
    ST_ULTRA       = 3'h3,  // ultra-deep power-down
    ST_ULTRA_EXIT  = 3'h2,  // waking from ultra-deep
    ST_DEEP        = 3'h6,  // deep power-down
    ST_DEEP_RESUME = 3'h7,  // waking from deep
    ST_CFG_PROG    = 3'h4   // nonvolatile page-size program
  } power_state_t;
endpackage

// ==== spi_byte_if.sv ====
// byte-level events from the serial front end to the command decoder
`timescale 1ns/10ps
interface spi_byte_if;
  logic       frame_start;  // pulse: chip select fell
  logic       frame_end;    // pulse: chip select rose
  logic       bit_strobe;   // pulse: one bit clocked in
  logic       byte_strobe;  // pulse: byte_data holds a whole byte
  logic [7:0] byte_data;    // last complete byte, msb first
  logic [2:0] byte_index;   // index of that byte, saturates at 7
  logic       aligned;      // clocked bit count is a multiple of 8
  logic       cs_low;       // synchronised chip select asserted
  // front end drives, decoder listens
  modport shifter (output frame_start, frame_end, bit_strobe, byte_strobe,
                   byte_data, byte_index, aligned, cs_low);
  modport decoder (input  frame_start, frame_end, bit_strobe, byte_strobe,
                   byte_data, byte_index, aligned, cs_low);
endinterface

// ==== spi_bit_shifter.sv ====
// pin synchroniser, clock edge finder and msb-first byte shifter
`timescale 1ns/10ps
module spi_bit_shifter (
  input  wire logic  clk,
  input  wire logic  rst_n,
  input  wire logic  cs_n,
  input  wire logic  sck,
  input  wire logic  si,
  spi_byte_if.shifter link
);
  // ****************************************
  // two-stage synchronisers
  // ****************************************
  logic [2:0] pin_in;   // {si, sck, cs_n}
  logic [2:0] meta_q;   // first stage, read only by sync_q
  logic [2:0] sync_q;   // second stage
  logic       sck_prev_q;
  logic       cs_prev_q;
  assign pin_in = {si, sck, cs_n};
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_sync
      // idle high so no false edge at release
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          meta_q[g] <= 1'b1;
          sync_q[g] <= 1'b1;
        end else begin
          meta_q[g] <= pin_in[g];
          sync_q[g] <= meta_q[g];
        end
      end
    end
  endgenerate
  // ****************************************
  // edge detection and shifting
  // ****************************************
  logic       cs_fall, cs_rise, sck_rise;
  logic [2:0] bit_idx_q;    // bit position inside current byte
  logic [6:0] shift_q;      // partial byte
  logic [2:0] byte_cnt_q;   // bytes completed, saturating
  assign cs_fall  = cs_prev_q & ~sync_q[0];
  assign cs_rise  = ~cs_prev_q & sync_q[0];
  assign sck_rise = ~sck_prev_q & sync_q[1] & ~sync_q[0];
  // rising serial clock samples data, msb first
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sck_prev_q <= 1'b1;
      cs_prev_q <= 1'b1;
      bit_idx_q <= 3'h0;
      shift_q <= 7'h00;
      byte_cnt_q <= 3'h0;
      link.frame_start <= 1'b0;
      link.frame_end <= 1'b0;
      link.bit_strobe <= 1'b0;
      link.byte_strobe <= 1'b0;
      link.byte_data <= 8'h00;
      link.byte_index <= 3'h0;
    end else begin
      sck_prev_q <= sync_q[1];
      cs_prev_q <= sync_q[0];
      link.frame_start <= cs_fall;
      link.frame_end <= cs_rise;
      link.bit_strobe <= sck_rise;
      link.byte_strobe <= sck_rise & (bit_idx_q == 3'h7);
      if (cs_fall) begin
        bit_idx_q <= 3'h0;    // new frame restarts counting
        byte_cnt_q <= 3'h0;
      end else if (sck_rise) begin
        shift_q <= {shift_q[5:0], sync_q[2]};
        bit_idx_q <= bit_idx_q + 3'h1;
        if (bit_idx_q == 3'h7) begin
          link.byte_data <= {shift_q, sync_q[2]};
          link.byte_index <= byte_cnt_q;
          if (byte_cnt_q != 3'h7) begin
            byte_cnt_q <= byte_cnt_q + 3'h1;
          end
        end
      end
    end
  end
  assign link.aligned = (bit_idx_q == 3'h0);
  assign link.cs_low  = ~sync_q[0];
endmodule

// ==== power_mode_page_config.sv ====
// power-state sequencing and nonvolatile page-size selection of the flash
// Overview of operation
// - deep power-down accepts only the resume command
// - resume opcode, chip select high, then resume delay
// - bad resume frame keeps deep power-down
// - ultra opcode, chip select high, entry delay
// - ultra entry discards both sram buffers
// - ultra-deep power-down ignores every command
// - bad ultra frame aborts back to standby
// - ultra command ignored during self-timed operation
// - short chip select pulse exits, dummy byte ignored
// - exit delay after pulse, earlier frames ignored
// - long chip select low exits; early bit ignored
// - page and buffer size 256 or 264 bytes
// - sequence ending a6h programs 256-byte pages
// - sequence ending a7h programs 264-byte pages
// - busy shown during page-size program cycle
// - size kept nonvolatile, active after program
// - power-up always lands in standby
// - deep opcode on byte boundary, not while busy
`include "power_mode_defines.svh"
`timescale 1ns/10ps
module power_mode_page_config
  import power_mode_pkg::*;
#(
  parameter int unsigned ULTRA_EXIT_CYC = `ULTRA_EXIT_CYC,   // wake time from ultra
  parameter int unsigned CFG_PROG_CYC   = `CONFIG_PROGRAM_CYC // page-size program time
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic cs_n,           // chip select pin, low active
  input  wire logic sck,            // serial clock pin
  input  wire logic si,             // serial data in pin
  input  wire logic busy_ext,       // other self-timed operation running
  input  wire logic nv_page_264,    // stored size bit, read after reset
  output logic       in_standby,
  output logic       in_deep,
  output logic       in_ultra,
  output logic       ready,         // status ready flag, low while busy
  output logic       page_264,      // current size, 1 = 264 bytes
  output logic [8:0] page_bytes,    // current page and buffer size
  output logic       buffer_discard, // pulse: sram buffers lost
  output logic       nv_write,      // pulse: store new size bit
  output logic       nv_write_264,  // value to store
  output logic       cmd_enable     // other decoders may act on frame
);

  // ****************************************
  // elaboration checks
  // ****************************************
  generate
    if (ULTRA_EXIT_CYC < 1 || CFG_PROG_CYC < 1) begin : g_bad_param
      $error("delay counts must be at least one cycle");
    end
  endgenerate

  // ****************************************
  // serial front end
  // ****************************************
  spi_byte_if link ();              // byte events from the shifter

  // synchronises pins and assembles bytes
  spi_bit_shifter u_shifter (
    .clk   (clk),
    .rst_n (rst_n),
    .cs_n  (cs_n),
    .sck   (sck),
    .si    (si),
    .link  (link)
  );

  // ****************************************
  // declarations
  // ****************************************
  power_state_t state_q;            // current power state
  power_state_t state_d;            // next power state
  logic [31:0]  timer_q;            // delay and low-time counter
  logic [31:0]  limit;              // count that ends current wait
  logic         timer_done;         // wait finished this cycle
  logic [7:0]   op_q;               // first byte of the frame
  logic         op_valid_q;         // first byte complete
  logic         cfg_ok_q;           // frame so far matches the size sequence
  logic         cfg_264_q;          // last byte selected 264
  logic         tgt_264_q;          // size being programmed
  logic         ignore_q;           // current frame must be dropped
  logic         load_done_q;        // stored size bit taken
  logic         end_ok;             // frame ended on a byte boundary
  logic         dev_busy;           // a self-timed operation runs
  logic         is_resume;
  logic         is_deep;
  logic         is_ultra;
  logic         standby_q;
  logic         deep_q;
  logic         ultra_q;
  logic         ready_q;
  logic         page_264_q;
  logic [8:0]   page_bytes_q;
  logic         discard_q;
  logic         nv_write_q;
  logic         cmd_enable_q;

  // ****************************************
  // frame classification
  // ****************************************
  // only whole bytes count; partial frames fall through
  assign end_ok    = link.frame_end & link.aligned & ~ignore_q;
  assign dev_busy  = (state_q == ST_CFG_PROG) | busy_ext;
  assign is_resume = op_valid_q & (op_q == `OP_RESUME_DEEP);
  assign is_deep   = op_valid_q & (op_q == `OP_ENTER_DEEP);
  assign is_ultra  = op_valid_q & (op_q == `OP_ENTER_ULTRA);

  // opcode capture; bytes after the first are ignored
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      op_q <= 8'h00;
      op_valid_q <= 1'b0;
    end else if (link.frame_start) begin
      op_valid_q <= 1'b0;            // fresh frame
    end else if (link.byte_strobe && link.byte_index == 3'h0) begin
      op_q <= link.byte_data;
      op_valid_q <= 1'b1;
    end
  end

  // tracks the four-byte size sequence; longer frames fail, shorter prefixes still match
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_ok_q <= 1'b0;
      cfg_264_q <= 1'b0;
    end else if (link.frame_start) begin
      cfg_ok_q <= 1'b0;
    end else if (link.byte_strobe) begin
      case (link.byte_index)
        3'h0: cfg_ok_q <= (link.byte_data == `CFG_BYTE0);
        3'h1: cfg_ok_q <= cfg_ok_q & (link.byte_data == `CFG_BYTE1);
        3'h2: cfg_ok_q <= cfg_ok_q & (link.byte_data == `CFG_BYTE2);
        `CFG_LAST_INDEX: begin
          // either last byte completes the sequence
          cfg_ok_q <= cfg_ok_q & ((link.byte_data == `CFG_BYTE3_256) |
                                  (link.byte_data == `CFG_BYTE3_264));
          cfg_264_q <= (link.byte_data == `CFG_BYTE3_264);
        end
        default: cfg_ok_q <= 1'b0;   // longer frame is no sequence
      endcase
    end
  end

  // ****************************************
  // frame ignore flag
  // ****************************************
  // frames begun while waking or programming are dropped whole
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ignore_q <= 1'b0;
    end else if (link.frame_start) begin
      // standby, deep and ultra judge the frame themselves
      ignore_q <= (state_q == ST_ULTRA_ENTRY) | (state_q == ST_ULTRA_EXIT) |
                  (state_q == ST_DEEP_RESUME) | (state_q == ST_CFG_PROG);
    end else if (link.bit_strobe && state_q == ST_ULTRA) begin
      ignore_q <= 1'b1;              // bit before wake: command lost
    end
  end

  // ****************************************
  // wait limits
  // ****************************************
  // count that ends the wait of each timed state
  always_comb begin
    limit = 32'd1;
    case (state_q)
      ST_ULTRA_ENTRY: limit = 32'(`ULTRA_ENTRY_CYC);
      ST_ULTRA:       limit = 32'(ULTRA_EXIT_CYC);
      ST_ULTRA_EXIT:  limit = 32'(ULTRA_EXIT_CYC);
      ST_DEEP_RESUME: limit = 32'(`RESUME_DELAY_CYC);
      ST_CFG_PROG:    limit = 32'(CFG_PROG_CYC);
      default:        limit = 32'd1;
    endcase
  end
  assign timer_done = (timer_q >= limit - 32'd1);

  // ****************************************
  // power state machine
  // ****************************************
  // next state from frame ends and finished waits
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_STANDBY: begin
        if (end_ok && is_deep && !dev_busy) begin
          state_d = ST_DEEP;
        end else if (end_ok && is_ultra && !dev_busy) begin
          state_d = ST_ULTRA_ENTRY;
        end else if (end_ok && cfg_ok_q && !dev_busy) begin
          state_d = ST_CFG_PROG;
        end
      end
      ST_ULTRA_ENTRY: begin
        if (timer_done) begin
          state_d = ST_ULTRA;
        end
      end
      ST_ULTRA: begin
        // commands dropped; pulse judged as chip select rises
        if (!link.cs_low && timer_q >= 32'(`EXIT_PULSE_MIN_CYC)) begin
          state_d = ST_ULTRA_EXIT;
        end else if (link.cs_low && timer_done) begin
          state_d = ST_STANDBY;      // held low long enough
        end
      end
      ST_ULTRA_EXIT: begin
        if (timer_done) begin
          state_d = ST_STANDBY;
        end
      end
      ST_DEEP: begin
        if (end_ok && is_resume) begin
          state_d = ST_DEEP_RESUME;  // anything else ignored
        end
      end
      ST_DEEP_RESUME: begin
        if (timer_done) begin
          state_d = ST_STANDBY;
        end
      end
      ST_CFG_PROG: begin
        if (timer_done) begin
          state_d = ST_STANDBY;
        end
      end
      default: state_d = ST_STANDBY;
    endcase
  end

  // state register; reset always lands in standby
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_STANDBY;
    end else begin
      state_q <= state_d;
    end
  end

  // ****************************************
  // delay timer
  // ****************************************
  // restarts on each state change; in ultra it times the low pulse
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      timer_q <= 32'd0;
    end else if (state_d != state_q) begin
      timer_q <= 32'd0;
    end else if (state_q == ST_ULTRA && !link.cs_low) begin
      timer_q <= 32'd0;              // chip select high, no pulse yet
    end else if (!timer_done || state_q == ST_ULTRA) begin
      if (timer_q != 32'hffffffff) begin
        timer_q <= timer_q + 32'd1;
      end
    end
  end

  // ****************************************
  // page size selection
  // ****************************************
  // target latched when programming starts; later frames cannot move it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tgt_264_q <= `PAGE_264_RESET;
    end else if (state_q == ST_STANDBY && state_d == ST_CFG_PROG) begin
      tgt_264_q <= cfg_264_q;
    end
  end

  // stored bit taken after reset, new size live once programmed
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      load_done_q <= 1'b0;
      page_264_q <= `PAGE_264_RESET;
      page_bytes_q <= `PAGE_BYTES_264;
    end else if (!load_done_q) begin
      load_done_q <= 1'b1;
      page_264_q <= nv_page_264;
      page_bytes_q <= nv_page_264 ? `PAGE_BYTES_264 : `PAGE_BYTES_256;
    end else if (state_q == ST_CFG_PROG && state_d == ST_STANDBY) begin
      page_264_q <= tgt_264_q;       // no power cycle needed
      page_bytes_q <= tgt_264_q ? `PAGE_BYTES_264 : `PAGE_BYTES_256;
    end
  end

  // nonvolatile store request at the end of the program cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      nv_write_q <= 1'b0;
    end else begin
      nv_write_q <= (state_q == ST_CFG_PROG) && (state_d == ST_STANDBY);
    end
  end

  // ****************************************
  // status and mode outputs
  // ****************************************
  // mode flags follow the next state so they match the state register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      standby_q <= 1'b1;
      deep_q <= 1'b0;
      ultra_q <= 1'b0;
    end else begin
      standby_q <= (state_d == ST_STANDBY);
      deep_q <= (state_d == ST_DEEP) | (state_d == ST_DEEP_RESUME);
      ultra_q <= (state_d == ST_ULTRA) | (state_d == ST_ULTRA_EXIT);
    end
  end

  // ready flag reads busy while the size bit programs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ready_q <= 1'b1;
    end else begin
      ready_q <= (state_d != ST_CFG_PROG) & ~busy_ext;
    end
  end

  // buffers lost on the step into ultra-deep
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      discard_q <= 1'b0;
    end else begin
      discard_q <= (state_q == ST_ULTRA_ENTRY) && (state_d == ST_ULTRA);
    end
  end

  // other decoders act only on accepted frames in standby
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_enable_q <= 1'b0;
    end else begin
      cmd_enable_q <= (state_q == ST_STANDBY) & ~ignore_q & link.cs_low;
    end
  end

  // ports straight from flops
  assign in_standby     = standby_q;
  assign in_deep        = deep_q;
  assign in_ultra       = ultra_q;
  assign ready          = ready_q;
  assign page_264       = page_264_q;
  assign page_bytes     = page_bytes_q;
  assign buffer_discard = discard_q;
  assign nv_write       = nv_write_q;
  assign nv_write_264   = tgt_264_q;
  assign cmd_enable     = cmd_enable_q;

endmodule

// ==== spi_host_model.sv ====
// host serial master model driving chip select, serial clock and data
`timescale 1ns/10ps
module spi_host_model (
  input  wire logic clk,
  output logic      cs_n,
  output logic      sck,
  output logic      si
);
  // idle: deselected, clock parked low
  initial begin
    cs_n = 1'b1;
    sck  = 1'b0;
    si   = 1'b0;
  end
  // ****************************************
  // one frame: low hold, then nbits msb first
  // ****************************************
  task automatic frame(input logic [39:0] d, input int nbits, input int hold);
    @(negedge clk);
    cs_n = 1'b0;
    repeat (hold + 4) @(negedge clk);
    for (int i = 0; i < nbits; i++) begin
      si = d[39-i]; // msb first
      repeat (4) @(negedge clk);
      sck = 1'b1;
      repeat (4) @(negedge clk);
      sck = 1'b0;
    end
    repeat (4) @(negedge clk);
    cs_n = 1'b1;
    si   = ~si; // released line loses its last value
    repeat (8) @(negedge clk);
  endtask
endmodule

// ==== power_mode_page_config_monitor.sv ====
// concurrent checks on the power and page-size control ports
`timescale 1ns/10ps
module power_mode_page_config_monitor #(
  parameter int unsigned ULTRA_EXIT_CYC = 20,
  parameter int unsigned CFG_PROG_CYC   = 20
) (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       busy_ext,
  input wire logic       in_standby,
  input wire logic       in_deep,
  input wire logic       in_ultra,
  input wire logic       ready,
  input wire logic       page_264,
  input wire logic [8:0] page_bytes,
  input wire logic       buffer_discard,
  input wire logic       nv_write,
  input wire logic       nv_write_264,
  input wire logic       cmd_enable
);
  // ****************************************
  // helper: skips the size load after reset
  // ****************************************
  logic [1:0] up_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) up_q <= 2'h0;
    else if (up_q != 2'h3) up_q <= up_q + 2'h1;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_state_excl: assert property ($onehot0({in_standby, in_deep, in_ultra}))
    else $error("power flags overlap");
  a_bytes_size: assert property (page_bytes == (page_264 ? 9'h108 : 9'h100))
    else $error("page bytes disagree with size");
  a_quiet_low: assert property ((in_deep || in_ultra) |-> !cmd_enable)
    else $error("command enabled while powered down");
  a_discard_once: assert property (buffer_discard |=> !buffer_discard)
    else $error("discard longer than one cycle");
  a_discard_ultra: assert property ($rose(in_ultra) |->
    buffer_discard || $past(buffer_discard))
    else $error("ultra entered without discard");
  a_nvw_apply: assert property (nv_write |->
    page_264 == nv_write_264 && !$past(ready))
    else $error("size store mismatched");
  a_size_hold: assert property ((up_q == 2'h3 && $changed(page_264)) |-> nv_write)
    else $error("size changed without store");
  a_wake_standby: assert property (($fell(in_ultra) || $fell(in_deep)) |->
    ##[0:2] in_standby)
    else $error("wake did not reach standby");
  a_busy_ready: assert property (busy_ext |=> !ready)
    else $error("ready while busy");
  c_store: cover property (nv_write);
  c_ultra_out: cover property ($fell(in_ultra));
  c_deep_out: cover property ($fell(in_deep));
endmodule
bind power_mode_page_config power_mode_page_config_monitor #(
  .ULTRA_EXIT_CYC(ULTRA_EXIT_CYC), .CFG_PROG_CYC(CFG_PROG_CYC)) u_monitor (
  .clk(clk), .rst_n(rst_n), .busy_ext(busy_ext), .in_standby(in_standby),
  .in_deep(in_deep), .in_ultra(in_ultra), .ready(ready), .page_264(page_264),
  .page_bytes(page_bytes), .buffer_discard(buffer_discard), .nv_write(nv_write),
  .nv_write_264(nv_write_264), .cmd_enable(cmd_enable));

// ==== tb_power_mode_page_config.sv ====
// self-checking bench for the power and page-size control
`timescale 1ns/10ps
module tb_power_mode_page_config;
  localparam int EXIT_CYC = 20; // shortened ultra exit
  localparam int PROG_CYC = 20; // shortened size program
  logic       clk, rst_n, cs_n, sck, si, busy_ext, nv_page_264;
  logic       in_standby, in_deep, in_ultra, ready, page_264;
  logic [8:0] page_bytes;
  logic       buffer_discard, nv_write, nv_write_264, cmd_enable;
  int         n_fail, cmp_count, m_st, m_264, disc_n, nvw_n, en_n, cyc, v, s;
  power_mode_page_config #(.ULTRA_EXIT_CYC(EXIT_CYC), .CFG_PROG_CYC(PROG_CYC)) u_dut (
    .clk(clk), .rst_n(rst_n), .cs_n(cs_n), .sck(sck), .si(si), .busy_ext(busy_ext),
    .nv_page_264(nv_page_264), .in_standby(in_standby), .in_deep(in_deep),
    .in_ultra(in_ultra), .ready(ready), .page_264(page_264), .page_bytes(page_bytes),
    .buffer_discard(buffer_discard), .nv_write(nv_write), .nv_write_264(nv_write_264),
    .cmd_enable(cmd_enable));
  spi_host_model u_host (.clk(clk), .cs_n(cs_n), .sck(sck), .si(si));
  // ****************************************
  // clock, pulse counters and hang limit
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    disc_n += buffer_discard;
    nvw_n  += nv_write;
    en_n   += cmd_enable;
    cyc++;
    if (cyc == 40000) begin
      n_fail++;
      $display("[ERR] timeout expected done seen hang");
      summarize();
    end
  end
  task automatic chk(input string nm, input logic [8:0] exp, input logic [8:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // frame through the host, then the reference model's decision
  task automatic send(input logic [39:0] d, input int n, input int hold);
    u_host.frame(d, n, hold);
    if (m_st == 2 && hold <= EXIT_CYC) m_st = 0; // frame eaten by the wake
    else begin
      if (m_st == 2) m_st = 0;
      if (n % 8 != 0 || n == 0) ;
      else if (m_st == 1) m_st = (d[39:32] == 8'hab) ? 0 : 1;
      else if (busy_ext) ;
      else if (d[39:32] == 8'hb9) m_st = 1;
      else if (d[39:32] == 8'h79) m_st = 2;
      else if (n == 32 && d[39:16] == 24'h3d2a80 && (d[15:8] | 8'h01) == 8'ha7) m_264 = d[8];
    end
  endtask
  // bounded wait for the model's state, then compare
  task automatic settle(input string nm);
    int k;
    k = 0;
    while (k < 3000 && !(in_standby === (m_st == 0) && in_deep === (m_st == 1)
           && in_ultra === (m_st == 2) && page_264 === m_264[0])) begin
      @(negedge clk);
      k++;
    end
    @(negedge clk); // let the pulse counters see the last edge
    chk("in_standby", {8'h0, m_st == 0}, {8'h0, in_standby});
    chk("in_deep", {8'h0, m_st == 1}, {8'h0, in_deep});
    chk("in_ultra", {8'h0, m_st == 2}, {8'h0, in_ultra});
    chk("page_bytes", m_264 ? 9'h108 : 9'h100, page_bytes);
    $display("test %s done", nm);
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    void'($urandom(32'h974c));
    rst_n = 1'b0;
    busy_ext = 1'b0;
    nv_page_264 = $urandom;
    m_st = 0;
    m_264 = nv_page_264;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    repeat (6) @(negedge clk);
    settle("reset");
    v = en_n;
    send({8'hb9, 32'h0}, 8, 0);
    settle("deep entry");
    chk("cmd_enable", 9'h1, 9'(en_n != v));
    send({8'h79, 32'h0}, 8, 0);
    settle("deep ignores");
    send({8'hab, 32'h0}, 7, 0);
    settle("short resume");
    send({16'hab5a, 24'h0}, 16, 0);
    settle("resume");
    send({8'h79, 32'h0}, 12, 0);
    settle("ultra abort");
    busy_ext = 1'b1;
    send({8'hb9, 32'h0}, 8, 0);
    send({8'h79, 32'h0}, 8, 0);
    settle("ultra busy");
    busy_ext = 1'b0;
    v = disc_n;
    send({8'h79, 32'h0}, 8, 0);
    settle("ultra entry");
    chk("discard", 9'h1, 9'(disc_n - v));
    send({8'hb9, 32'h0}, 8, 0);
    settle("ultra dummy");
    send({8'h79, 32'h0}, 8, 0);
    settle("ultra again");
    send(40'h0, 0, 1);
    settle("exit pulse");
    send({8'h79, 32'h0}, 8, 0);
    settle("ultra again");
    send(40'h0, 0, 1);
    v = en_n;
    u_host.frame({8'hb9, 32'h0}, 8, 0);
    settle("early frame");
    chk("cmd_enable", 9'h0, 9'(en_n != v));
    send({8'h79, 32'h0}, 8, 0);
    settle("ultra again");
    send({8'hb9, 32'h0}, 8, EXIT_CYC + 10);
    settle("long low");
    send({8'hab, 32'h0}, 8, 0);
    settle("resume two");
    s = $urandom % 2;
    for (int i = 0; i < 2; i++) begin
      v = nvw_n;
      send({24'h3d2a80, 7'h53, 1'(s ^ i), 8'h0}, 32, 0);
      chk("ready", 9'h0, {8'h0, ready});
      settle("size");
      chk("nv_write", 9'h1, 9'(nvw_n - v));
      chk("nv_write_264", 9'(m_264), {8'h0, nv_write_264});
    end
    send({24'h3d2a80, 7'h53, 1'(~s), 8'h0}, 40, 0);
    settle("size five bytes");
    busy_ext = 1'b1;
    send({24'h3d2a80, 7'h53, 1'(~s), 8'h0}, 32, 0);
    settle("size busy");
    busy_ext = 1'b0;
    summarize();
  end
endmodule
